// ==== common/mgfs_defs.svh ====
// Offsets, field positions, reset values and reserved-bit values of the register slice
`ifndef MGFS_DEFS_SVH
`define MGFS_DEFS_SVH

`define OFS_SCRATCH 8'h19
`define OFS_PINCFG 8'h1a
`define OFS_FREQ 8'h1b
`define OFS_STATUS 8'h1c

`define RST_SCRATCH 8'h01
`define RST_PINCFG 8'h00
`define RST_FREQ 8'h00

`define PINCFG_GLB_LEVEL 7
`define PINCFG_GLB_DIR 5
`define PINCFG_GLB_EN 4
`define PINCFG_P9_LEVEL 3
`define PINCFG_P9_DIR 1
`define PINCFG_P9_EN 0

`define STS_DUAL 4
`define STS_AUDIO 3
`define STS_LOCK 0
`define STS_FIXED 8'h20

`define FREQ_MAX 8'hff
`define UNMAPPED_READ 8'h00

`endif

// ==== common/mgfs_pkg.sv ====
// Types shared by the register slice and its users
package mgfs_pkg;

  typedef enum logic [1:0] {
    PIN_FUNC,
    PIN_HIZ,
    PIN_DRIVE,
    PIN_INPUT
  } pin_mode_e;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } reg_req_s;

  typedef struct packed {
    logic lockA;
    logic lockB;
    logic dualMode;
    logic audioLock;
  } status_in_s;

  typedef struct packed {
    logic level;
    logic oe;
  } pin_drive_s;

  typedef struct packed {
    logic [7:0] scratch;
    logic [7:0] pinCfg;
    logic [7:0] freqCount;
    logic [7:0] oscLeft;
    logic windowBusy;
    logic [1:0] pixSync;
    logic pixPrev;
    logic [1:0] oscSync;
    logic oscPrev;
    status_in_s stsMeta;
    status_in_s stsSync;
    logic [1:0] pinInSync;
    logic [1:0] remEnSync;
    logic [1:0] remLvlSync;
    logic [7:0] rdData;
    logic rdValid;
    pin_drive_s pin9;
    pin_drive_s allPins;
    logic pin9InLevel;
    reg_req_s reqEcho;
  } regs_state_s;

endpackage : mgfs_pkg

// ==== core/mailbox_gpio_freq_status_regs.sv ====
// Scratch, pin override, pixel clock rate counter and status registers
`timescale 1ns/1ns
`include "mgfs_defs.svh"
// Overview of operation
// - Scratch register at 0x19, read/write, resets to 1, no hardware effect.
// - Pin with own pair 00 and global pair 01 (forced output) drives global level bit 7.
// - Global pair 00 functional, 10 high-Z, 01 forced output, 11 forced input.
// - Pin's own direction and enable settings, other than pair 00, take priority over global settings.
// - Pin 9 drives bit 3 when enabled, output direction, remote control off.
// - Pin 9 pair 00 follows the global pair, 10 high-Z, 01 output, 11 input.
// - Write to 0x1b starts pixel edge count over written number of oscillator periods.
// - Read of 0x1b returns edges counted in latest window, not written value.
// - Edge count saturates at 0xff and holds there.
// - Status bit 4 reads 1 in dual-link mode, 0 in single-link mode.
// - Status bit 3 reads 1 when audio PLL is locked.
// - Status bit 0 reads receiver lock; dual-link needs both channels locked.
module mailbox_gpio_freq_status_regs
  import mgfs_pkg::*;
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input mgfs_pkg::reg_req_s regReq, // Register access from the serial bus controller
  output mgfs_pkg::reg_req_s unusedReqEcho, // Request seen in the previous cycle
  output logic [7:0] rdData, // Read data
  output logic rdValid, // Read data valid, one cycle
  input wire logic pixClk, // Pixel clock, sampled
  input wire logic oscClk, // Oscillator clock, sampled
  input mgfs_pkg::status_in_s statusIn, // Lock and mode levels from the receiver
  input wire logic funcLevel, // Functional level for pin 9
  input wire logic remoteEn, // Remote control of pin 9 enabled
  input wire logic remoteLevel, // Level received from the far end
  input wire logic pin9In, // Pin 9 pad input
  output logic pin9Out, // Pin 9 pad output
  output logic pin9Oe, // Pin 9 pad output enable
  output logic pin9InLevel, // Synchronised pin 9 level in input mode
  output logic globalOut, // Global override level for other pins
  output logic globalOe, // Global override enable for other pins
  output logic [7:0] freqCount // Current edge count
);
  import mgfs_pkg::*;

  regs_state_s stateReg;
  regs_state_s stateNext;

  // ==========================================================================
  // Helpers
  function automatic pin_mode_e decodePair(input logic dir, input logic en);
    case ({dir, en})
      2'b00: decodePair = PIN_FUNC;
      2'b10: decodePair = PIN_HIZ;
      2'b01: decodePair = PIN_DRIVE;
      default: decodePair = PIN_INPUT;
    endcase
  endfunction : decodePair

  function automatic logic [7:0] statusByte(input status_in_s s);
    logic [7:0] b;
    b = `STS_FIXED;
    b[`STS_DUAL] = s.dualMode;
    b[`STS_AUDIO] = s.audioLock;
    b[`STS_LOCK] = s.dualMode ? (s.lockA & s.lockB) : s.lockA;
    statusByte = b;
  endfunction : statusByte

  // ==========================================================================
  // Next state
  logic wrFreq;
  logic pixRise;
  logic oscRise;
  pin_mode_e glbMode;
  pin_mode_e ownMode;

  always_comb
  begin
    stateNext = stateReg;
    wrFreq = regReq.wrEn && (regReq.addr == `OFS_FREQ);
    pixRise = stateReg.pixSync[1] && !stateReg.pixPrev;
    oscRise = stateReg.oscSync[1] && !stateReg.oscPrev;
    glbMode = decodePair(stateReg.pinCfg[`PINCFG_GLB_DIR], stateReg.pinCfg[`PINCFG_GLB_EN]);
    ownMode = decodePair(stateReg.pinCfg[`PINCFG_P9_DIR], stateReg.pinCfg[`PINCFG_P9_EN]);

    // Synchronisers; the first stage feeds only the second
    stateNext.pixSync = {stateReg.pixSync[0], pixClk};
    stateNext.pixPrev = stateReg.pixSync[1];
    stateNext.oscSync = {stateReg.oscSync[0], oscClk};
    stateNext.oscPrev = stateReg.oscSync[1];
    stateNext.stsMeta = statusIn;
    stateNext.stsSync = stateReg.stsMeta;
    stateNext.pinInSync = {stateReg.pinInSync[0], pin9In};
    stateNext.remEnSync = {stateReg.remEnSync[0], remoteEn};
    stateNext.remLvlSync = {stateReg.remLvlSync[0], remoteLevel};

    // Register writes; status is read-only and ignores writes
    if (regReq.wrEn)
    begin
      case (regReq.addr)
        `OFS_SCRATCH: stateNext.scratch = regReq.wrData;
        `OFS_PINCFG: stateNext.pinCfg = regReq.wrData;
        default: ;
      endcase
    end

    // Rate counter window
    if (wrFreq)
    begin
      stateNext.freqCount = 8'h00;
      stateNext.oscLeft = regReq.wrData;
      stateNext.windowBusy = (regReq.wrData != 8'h00);
    end
    else if (stateReg.windowBusy)
    begin
      if (pixRise && (stateReg.freqCount != `FREQ_MAX))
        stateNext.freqCount = stateReg.freqCount + 8'h01;
      if (oscRise)
      begin
        stateNext.oscLeft = stateReg.oscLeft - 8'h01;
        stateNext.windowBusy = (stateReg.oscLeft != 8'h01);
      end
    end

    // Register reads
    stateNext.rdValid = regReq.rdEn;
    stateNext.rdData = stateReg.rdData;
    if (regReq.rdEn)
    begin
      case (regReq.addr)
        `OFS_SCRATCH: stateNext.rdData = stateReg.scratch;
        `OFS_PINCFG: stateNext.rdData = stateReg.pinCfg;
        `OFS_FREQ: stateNext.rdData = stateReg.freqCount;
        `OFS_STATUS: stateNext.rdData = statusByte(stateReg.stsSync);
        default: stateNext.rdData = `UNMAPPED_READ;
      endcase
    end

    // Global override, offered to every pin
    case (glbMode)
      PIN_DRIVE: stateNext.allPins = '{level: stateReg.pinCfg[`PINCFG_GLB_LEVEL], oe: 1'b1};
      PIN_FUNC: stateNext.allPins = '{level: funcLevel, oe: 1'b1};
      default: stateNext.allPins = '{level: 1'b0, oe: 1'b0};
    endcase

    // Pin 9: own setting wins unless it is functional
    case (ownMode)
      PIN_DRIVE:
      begin
        if (stateReg.remEnSync[1])
          stateNext.pin9 = '{level: stateReg.remLvlSync[1], oe: 1'b1};
        else
          stateNext.pin9 = '{level: stateReg.pinCfg[`PINCFG_P9_LEVEL], oe: 1'b1};
      end
      PIN_HIZ: stateNext.pin9 = '{level: 1'b0, oe: 1'b0};
      PIN_INPUT: stateNext.pin9 = '{level: 1'b0, oe: 1'b0};
      default:
      begin
        case (glbMode)
          PIN_DRIVE: stateNext.pin9 = '{level: stateReg.pinCfg[`PINCFG_GLB_LEVEL], oe: 1'b1};
          PIN_FUNC: stateNext.pin9 = '{level: funcLevel, oe: 1'b1};
          default: stateNext.pin9 = '{level: 1'b0, oe: 1'b0};
        endcase
      end
    endcase
    stateNext.pin9InLevel = stateReg.pinInSync[1];
    stateNext.reqEcho = regReq;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stateReg <= '0;
      stateReg.scratch <= `RST_SCRATCH;
      stateReg.pinCfg <= `RST_PINCFG;
      stateReg.freqCount <= `RST_FREQ;
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  assign unusedReqEcho = stateReg.reqEcho;
  assign rdData = stateReg.rdData;
  assign rdValid = stateReg.rdValid;
  assign pin9Out = stateReg.pin9.level;
  assign pin9Oe = stateReg.pin9.oe;
  assign pin9InLevel = stateReg.pin9InLevel;
  assign globalOut = stateReg.allPins.level;
  assign globalOe = stateReg.allPins.oe;
  assign freqCount = stateReg.freqCount;

  // ==========================================================================
  // Checks
  a_scratch_write: assert property (@(posedge clk) disable iff (!nrst)
    (regReq.wrEn && regReq.addr == `OFS_SCRATCH) |=> (stateReg.scratch == $past(regReq.wrData)))
    else $error("scratch write lost");

  a_global_drive: assert property (@(posedge clk) disable iff (!nrst)
    (stateReg.pinCfg[1:0] == 2'b00 && stateReg.pinCfg[5:4] == 2'b01)
    |=> (pin9Oe && pin9Out == $past(stateReg.pinCfg[7])))
    else $error("global level not driven");

  a_global_hiz: assert property (@(posedge clk) disable iff (!nrst)
    (stateReg.pinCfg[1:0] == 2'b00 && stateReg.pinCfg[5]) |=> (!pin9Oe && !globalOe))
    else $error("global high impedance broken");

  a_pin_priority: assert property (@(posedge clk) disable iff (!nrst)
    (stateReg.pinCfg[1:0] == 2'b10) |=> !pin9Oe)
    else $error("own setting lost priority");

  a_local_drive: assert property (@(posedge clk) disable iff (!nrst)
    (stateReg.pinCfg[1:0] == 2'b01 && !stateReg.remEnSync[1])
    |=> (pin9Oe && pin9Out == $past(stateReg.pinCfg[3])))
    else $error("local level not driven");

  a_pin_input: assert property (@(posedge clk) disable iff (!nrst)
    (stateReg.pinCfg[1:0] == 2'b11) |=> !pin9Oe)
    else $error("input mode drives pin");

  a_count_start: assert property (@(posedge clk) disable iff (!nrst)
    wrFreq |=> (freqCount == 8'h00 && stateReg.oscLeft == $past(regReq.wrData)))
    else $error("count not restarted");

  a_count_read: assert property (@(posedge clk) disable iff (!nrst)
    (regReq.rdEn && regReq.addr == `OFS_FREQ) |=> (rdValid && rdData == $past(freqCount)))
    else $error("count read wrong");

  a_count_sat: assert property (@(posedge clk) disable iff (!nrst)
    (freqCount == `FREQ_MAX && !wrFreq) |=> (freqCount == `FREQ_MAX))
    else $error("count wrapped");

  a_status_read: assert property (@(posedge clk) disable iff (!nrst)
    (regReq.rdEn && regReq.addr == `OFS_STATUS)
    |=> (rdData[5] && rdData[4] == $past(stateReg.stsSync.dualMode)
      && rdData[3] == $past(stateReg.stsSync.audioLock)
      && rdData[0] == $past(stateReg.stsSync.lockA && (stateReg.stsSync.lockB || !stateReg.stsSync.dualMode))))
    else $error("status read wrong");

endmodule : mailbox_gpio_freq_status_regs

// ==== bench/mgfs_host.sv ====
// Host model issuing strobe accesses on the register port
`timescale 1ns/1ns
module mgfs_host
  import mgfs_pkg::*;
(
  input wire logic clk, // System clock
  output mgfs_pkg::reg_req_s regReq, // Register request
  input wire logic [7:0] rdData, // Read data
  input wire logic rdValid // Read data valid
);
  initial regReq = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    regReq = '{1'b1, 1'b0, a, d};
    @(posedge clk) #1;
    regReq = '0;
  endtask : wr
  // Waits a bounded time for the valid strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk) #1;
    regReq = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) #1;
    regReq = '0;
    while (rdValid !== 1'b1 && n < 8)
    begin
      @(posedge clk) #1;
      n++;
    end
    d = rdData;
  endtask : rd
endmodule : mgfs_host

// ==== bench/mailbox_gpio_freq_status_regs_test.sv ====
// Self-checking testbench of the register slice
`timescale 1ns/1ns
module mailbox_gpio_freq_status_regs_test;
  import mgfs_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pixClk = 1'b0;
  logic oscClk = 1'b0;
  logic funcLevel = 1'b0;
  logic remoteEn = 1'b0;
  logic remoteLevel = 1'b0;
  logic pin9In = 1'b0;
  status_in_s statusIn = '0;
  reg_req_s regReq;
  logic [7:0] rdData, freqCount, v;
  logic rdValid, pin9Out, pin9Oe, pin9InLevel, globalOut, globalOe;
  reg_req_s reqEcho;
  int nFail = 0;
  int checksDone = 0;
  always #5 clk = ~clk;
  always #40 pixClk = ~pixClk;
  always #200 oscClk = ~oscClk;
  mgfs_host host (.clk(clk), .regReq(regReq), .rdData(rdData), .rdValid(rdValid));
  mailbox_gpio_freq_status_regs DUT (.clk(clk), .nrst(nrst), .regReq(regReq), .unusedReqEcho(reqEcho),
    .rdData(rdData), .rdValid(rdValid), .pixClk(pixClk), .oscClk(oscClk), .statusIn(statusIn),
    .funcLevel(funcLevel), .remoteEn(remoteEn), .remoteLevel(remoteLevel), .pin9In(pin9In),
    .pin9Out(pin9Out), .pin9Oe(pin9Oe), .pin9InLevel(pin9InLevel), .globalOut(globalOut),
    .globalOe(globalOe), .freqCount(freqCount));
  // ==========================================
  // Checking helpers
  task automatic chkr(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    checksDone++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      nFail++;
      $display("BAD %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask : chkr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    chkr(got, exp, exp);
  endtask : chk
  // Valid must have arrived within the host's bound, else the data is stale
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, v);
    chk(rdValid, 8'h01);
    chk(v, exp);
  endtask : rdchk
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic wrapUp;
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrapUp
  // ==========================================
  // Scenarios
  task automatic t_regs;
    rdchk(8'h19, 8'h01);
    rdchk(8'h1a, 8'h00);
    rdchk(8'h1c, 8'h20);
    rdchk(8'h30, 8'h00);
    host.wr(8'h19, 8'ha5);
    chk({reqEcho.wrEn, reqEcho.rdEn, reqEcho.addr[5:0]}, 8'h99);
    chk(reqEcho.wrData, 8'ha5);
    host.wr(8'h1c, 8'hff);
    host.wr(8'h40, 8'h5a);
    rdchk(8'h19, 8'ha5);
    rdchk(8'h1c, 8'h20);
    $display("test registers done");
  endtask : t_regs
  task automatic t_status;
    for (int i = 0; i < 16; i++)
    begin
      statusIn = i[3:0];
      settle();
      rdchk(8'h1c, {2'b00, 1'b1, i[1], i[0], 2'b00, i[1] ? i[3] & i[2] : i[3]});
    end
    statusIn = '0;
    $display("test status done");
  endtask : t_status
  task automatic t_pins;
    for (int g = 0; g < 4; g++)
    begin
      host.wr(8'h1a, {1'b1, 1'b0, g[1:0], 4'h0});
      settle();
      chk(globalOe, !g[1]);
      if (!g[1]) chk(globalOut, g[0]);
    end
    funcLevel = 1'b1;
    host.wr(8'h1a, 8'h00);
    settle();
    chk({globalOe, globalOut, pin9Oe, pin9Out}, 8'h0f);
    funcLevel = 1'b0;
    for (int p = 0; p < 4; p++)
    begin
      host.wr(8'h1a, {4'h0, 2'b10, p[1:0]});
      settle();
      chk(pin9Oe, !p[1]);
      if (!p[1]) chk(pin9Out, p[0]);
    end
    host.wr(8'h1a, 8'h39);
    settle();
    chk({pin9Oe, pin9Out}, 8'h03);
    remoteEn = 1'b1;
    settle();
    settle();
    chk(pin9Out, 8'h00);
    remoteEn = 1'b0;
    host.wr(8'h1a, 8'h0b);
    pin9In = 1'b1;
    settle();
    settle();
    chk({pin9Oe, pin9InLevel}, 8'h01);
    $display("test pins done");
  endtask : t_pins
  task automatic t_freq;
    host.wr(8'h1b, 8'h00);
    settle();
    rdchk(8'h1b, 8'h00);
    host.wr(8'h1b, 8'h08);
    repeat (400) @(posedge clk);
    host.rd(8'h1b, v);
    chkr(v, 8'd34, 8'd41);
    host.wr(8'h1b, 8'hff);
    repeat (2500) @(posedge clk);
    rdchk(8'h1b, 8'hff);
    host.wr(8'h1b, 8'h08);
    chk(freqCount, 8'h00);
    host.rd(8'h1b, v);
    chkr(v, 8'h00, 8'h01);
    $display("test frequency done");
  endtask : t_freq
  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    t_regs();
    t_status();
    t_pins();
    t_freq();
    wrapUp();
  end
  initial
  begin
    #100000;
    nFail++;
    wrapUp();
  end
endmodule : mailbox_gpio_freq_status_regs_test
